// File: src/dram_mr_pkg.sv
// constants, command and setpoint carriers for the dram mode register file
package dram_mr_pkg;

	// ----------------------------------------------------------------
	// mode register addresses
	// ----------------------------------------------------------------
	localparam int MA_W = 6;
	localparam int DATA_W = 8;
	localparam logic [5:0] MA_PROTECT = 6'h03;
	localparam logic [5:0] MA_THERMAL = 6'h04;
	localparam logic [5:0] MA_MAKER = 6'h05;
	localparam logic [5:0] MA_REV_FIRST = 6'h06;
	localparam logic [5:0] MA_REV_SECOND = 6'h07;
	localparam logic [5:0] MA_GEOMETRY = 6'h08;
	localparam logic [5:0] MA_CAL_RESTORE = 6'h0A;
	localparam logic [5:0] MA_TERM = 6'h0B;
	localparam logic [5:0] MA_CA_REF = 6'h0C;
	localparam logic [5:0] MA_SETPOINT = 6'h0D;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int PROTECT_BIT = 2;
	localparam int TEMP_FLAG_BIT = 7;
	localparam int THERM_WR_LO = 3;
	localparam int THERM_WR_HI = 6;
	localparam int ENTRY_BIT = 4;
	localparam int ENTRY_IDX = ENTRY_BIT - THERM_WR_LO;
	localparam int CAL_RESTORE_BIT = 0;
	localparam int DQ_TERM_LO = 0;
	localparam int CA_TERM_LO = 4;
	localparam int REF_RANGE_BIT = 6;
	localparam int WSP_BIT = 6;
	localparam int OSP_BIT = 7;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] CODE_NOMINAL = 3'h3;
	localparam logic [2:0] CODE_DERATE = 3'h6;
	localparam logic [2:0] TERM_RESERVED = 3'h7;
	localparam logic [2:0] TERM_RESET = 3'h0;
	localparam logic [5:0] REF_CODE_MAX = 6'h32;
	localparam logic [5:0] REF_CODE_RESET = 6'h0D;
	localparam logic REF_RANGE_RESET = 1'b1;
	localparam logic [3:0] THERM_WR_RESET = 4'h0;
	localparam logic [7:0] GEOMETRY_VALUE = 8'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;

	typedef struct packed {
		logic write;
		logic [5:0] addr;
		logic [7:0] data;
	} mr_cmd_t;

	typedef struct packed {
		logic [2:0] dq_term;
		logic [2:0] ca_term;
		logic ref_range;
		logic [5:0] ref_code;
	} setpoint_t;

	localparam setpoint_t SETPOINT_RESET = '{
		dq_term: TERM_RESET,
		ca_term: TERM_RESET,
		ref_range: REF_RANGE_RESET,
		ref_code: REF_CODE_RESET
	};

	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_WAIT = 2'b01
	} link_state_t;

endpackage

// File: src/dram_mode_register_file.sv
// mode register file: thermal status, identity, termination and reference level
`timescale 1ns/10ps
module dram_mode_register_file import dram_mr_pkg::*; #(
	parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
	parameter logic [7:0] REV_FIRST = 8'h00,
	parameter logic [7:0] REV_SECOND = 8'h00
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic link_clk,
	input wire logic cmd_valid,
	input wire mr_cmd_t cmd,
	output logic cmd_ready,
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic [2:0] temp_code,
	input wire logic derate_req,
	input wire logic init_done,
	input wire logic cal_pin_grounded,
	output logic repair_mode,
	output logic [1:0] thermal_offset,
	output logic zq_restore,
	output logic cal_default_only,
	output logic [2:0] dq_term,
	output logic [2:0] ca_term,
	output logic [5:0] ref_code,
	output logic ref_range
);

	// ----------------------------------------------------------------
	// link domain: command capture and answer
	// ----------------------------------------------------------------
	logic lrst_s1_reg, lrst_s2_reg;
	logic link_rst_n;
	link_state_t link_state_reg;
	mr_cmd_t hold_reg;
	logic req_tgl_reg;
	logic ack_s1_reg, ack_s2_reg, ack_s3_reg;
	logic ready_reg, rd_valid_reg;
	logic [7:0] rd_data_reg;
	logic ack_tgl_reg;
	logic [7:0] resp_data_reg;
	wire ack_pulse = ack_s2_reg ^ ack_s3_reg;
	wire cmd_take = (link_state_reg == LINK_IDLE) && ready_reg && cmd_valid;

	// reset release is retimed so the link logic leaves reset cleanly
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			lrst_s1_reg <= 1'b0;
			lrst_s2_reg <= 1'b0;
		end else begin
			lrst_s1_reg <= 1'b1;
			lrst_s2_reg <= lrst_s1_reg;
		end
	end
	assign link_rst_n = lrst_s2_reg;

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end else begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	// the held command stays still until the answer toggles back
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			link_state_reg <= LINK_IDLE;
			hold_reg <= '0;
			req_tgl_reg <= 1'b0;
			ready_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= READ_ZERO;
		end else begin
			rd_valid_reg <= 1'b0;
			case (link_state_reg)
				LINK_IDLE: begin
					ready_reg <= 1'b1;
					if (cmd_take) begin
						hold_reg <= cmd;
						req_tgl_reg <= ~req_tgl_reg;
						ready_reg <= 1'b0;
						link_state_reg <= LINK_WAIT;
					end
				end
				LINK_WAIT: begin
					if (ack_pulse) begin
						ready_reg <= 1'b1;
						rd_valid_reg <= ~hold_reg.write;
						rd_data_reg <= resp_data_reg;
						link_state_reg <= LINK_IDLE;
					end
				end
				default: begin
					link_state_reg <= LINK_IDLE;
				end
			endcase
		end
	end

	assign cmd_ready = ready_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;

	// ----------------------------------------------------------------
	// core domain: synchronisers
	// ----------------------------------------------------------------
	logic req_s1_reg, req_s2_reg, req_s3_reg;
	logic [2:0] temp_s1_reg, temp_s2_reg;
	logic derate_s1_reg, derate_s2_reg;
	logic init_s1_reg, init_s2_reg;
	logic cal_s1_reg, cal_s2_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
			temp_s1_reg <= CODE_NOMINAL;
			temp_s2_reg <= CODE_NOMINAL;
			derate_s1_reg <= 1'b0;
			derate_s2_reg <= 1'b0;
			init_s1_reg <= 1'b0;
			init_s2_reg <= 1'b0;
			cal_s1_reg <= 1'b0;
			cal_s2_reg <= 1'b0;
		end else if (ce) begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
			temp_s1_reg <= temp_code;
			temp_s2_reg <= temp_s1_reg;
			derate_s1_reg <= derate_req;
			derate_s2_reg <= derate_s1_reg;
			init_s1_reg <= init_done;
			init_s2_reg <= init_s1_reg;
			cal_s1_reg <= cal_pin_grounded;
			cal_s2_reg <= cal_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// core domain: address decode
	// ----------------------------------------------------------------
	wire req_pulse = req_s2_reg ^ req_s3_reg;
	wire mr_wr = req_pulse && hold_reg.write;
	wire mr_rd = req_pulse && !hold_reg.write;
	wire [7:0] wdata = hold_reg.data;
	wire sel_protect = hold_reg.addr == MA_PROTECT;
	wire sel_thermal = hold_reg.addr == MA_THERMAL;
	wire sel_cal = hold_reg.addr == MA_CAL_RESTORE;
	wire sel_term = hold_reg.addr == MA_TERM;
	wire sel_ref = hold_reg.addr == MA_CA_REF;
	wire sel_setpoint = hold_reg.addr == MA_SETPOINT;
	wire wr_thermal = mr_wr && sel_thermal;
	wire rd_thermal = mr_rd && sel_thermal;
	wire wr_term = mr_wr && sel_term;
	wire wr_ref = mr_wr && sel_ref;

	// ----------------------------------------------------------------
	// thermal status and repair entry
	// ----------------------------------------------------------------
	logic [2:0] refresh_code_reg;
	logic temp_flag_reg;
	logic init_seen_reg;
	logic [3:0] therm_wr_reg;
	logic protect_reg;

	// the sensor reports the multiplier; derating overrides it with its own code
	wire [2:0] code_now = derate_s2_reg ? CODE_DERATE : temp_s2_reg;
	// before initialisation the nominal code stands and no change is tracked
	wire code_change = init_s2_reg && (code_now != refresh_code_reg);
	wire [2:0] refresh_code_next = code_change ? code_now : refresh_code_reg;
	// a change in the read cycle wins over the clear so it is never lost
	wire temp_flag_next = code_change ? 1'b1 : (rd_thermal ? 1'b0 : temp_flag_reg);
	wire entry_refused = protect_reg && wdata[ENTRY_BIT];
	wire entry_next = entry_refused ? therm_wr_reg[ENTRY_IDX] : wdata[ENTRY_BIT];
	wire [3:0] therm_wr_next = wr_thermal ?
		{wdata[THERM_WR_HI:ENTRY_BIT + 1], entry_next, wdata[THERM_WR_LO]} :
		therm_wr_reg;
	wire protect_next = protect_reg || (mr_wr && sel_protect && wdata[PROTECT_BIT]);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refresh_code_reg <= CODE_NOMINAL;
			temp_flag_reg <= 1'b0;
			init_seen_reg <= 1'b0;
			therm_wr_reg <= THERM_WR_RESET;
			protect_reg <= 1'b0;
		end else if (ce) begin
			refresh_code_reg <= refresh_code_next;
			temp_flag_reg <= temp_flag_next;
			init_seen_reg <= init_seen_reg || init_s2_reg;
			therm_wr_reg <= therm_wr_next;
			protect_reg <= protect_next;
		end
	end

	// ----------------------------------------------------------------
	// calibration strap and restore
	// ----------------------------------------------------------------
	logic [1:0] strap_cnt_reg;
	logic cal_default_reg, zq_restore_reg;
	// the pin synchroniser still holds its reset value for two edges after release
	wire strap_taken = strap_cnt_reg == 2'h3;

	// the pin may not move while powered, so it is caught once after release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_reg <= 2'h0;
			cal_default_reg <= 1'b0;
			zq_restore_reg <= 1'b0;
		end else if (ce) begin
			strap_cnt_reg <= strap_taken ? strap_cnt_reg : strap_cnt_reg + 2'h1;
			if (!strap_taken) begin
				cal_default_reg <= cal_s2_reg;
			end
			zq_restore_reg <= mr_wr && sel_cal && wdata[CAL_RESTORE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// setpoint copies
	// ----------------------------------------------------------------
	setpoint_t sp_reg [2];
	logic wsp_reg, osp_reg;
	wire term_dq_ok = wdata[DQ_TERM_LO +: 3] != TERM_RESERVED;
	wire term_ca_ok = wdata[CA_TERM_LO +: 3] != TERM_RESERVED;
	wire ref_code_ok = wdata[5:0] <= REF_CODE_MAX;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wsp_reg <= 1'b0;
			osp_reg <= 1'b0;
		end else if (ce && mr_wr && sel_setpoint) begin
			wsp_reg <= wdata[WSP_BIT];
			osp_reg <= wdata[OSP_BIT];
		end
	end

	// only the copy named by the write setpoint takes a write
	for (genvar g = 0; g < 2; g++) begin : g_copy
		wire hit = wsp_reg == 1'(g);
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				sp_reg[g] <= SETPOINT_RESET;
			end else if (ce && hit) begin
				if (wr_term && term_dq_ok) begin
					sp_reg[g].dq_term <= wdata[DQ_TERM_LO +: 3];
				end
				if (wr_term && term_ca_ok) begin
					sp_reg[g].ca_term <= wdata[CA_TERM_LO +: 3];
				end
				if (wr_ref) begin
					sp_reg[g].ref_range <= wdata[REF_RANGE_BIT];
				end
				if (wr_ref && ref_code_ok) begin
					sp_reg[g].ref_code <= wdata[5:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// operating outputs
	// ----------------------------------------------------------------
	setpoint_t act_reg;
	wire setpoint_t act_sel = sp_reg[osp_reg];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			act_reg <= SETPOINT_RESET;
		end else if (ce) begin
			act_reg <= act_sel;
		end
	end

	assign repair_mode = therm_wr_reg[ENTRY_IDX];
	assign thermal_offset = therm_wr_reg[3:2];
	assign zq_restore = zq_restore_reg;
	assign cal_default_only = cal_default_reg;
	assign dq_term = act_reg.dq_term;
	assign ca_term = act_reg.ca_term;
	assign ref_code = act_reg.ref_code;
	assign ref_range = act_reg.ref_range;

	// ----------------------------------------------------------------
	// read answer
	// ----------------------------------------------------------------
	// write-only fields and unmapped addresses answer zero
	wire setpoint_t rd_sp = sp_reg[wsp_reg];
	wire [7:0] rd_mux =
		sel_thermal ? {temp_flag_reg, 4'h0, refresh_code_reg} :
		hold_reg.addr == MA_MAKER ? MAKER_ID :
		hold_reg.addr == MA_REV_FIRST ? REV_FIRST :
		hold_reg.addr == MA_REV_SECOND ? REV_SECOND :
		hold_reg.addr == MA_GEOMETRY ? GEOMETRY_VALUE :
		sel_ref ? {1'b0, rd_sp.ref_range, rd_sp.ref_code} :
		sel_setpoint ? {osp_reg, wsp_reg, 6'h00} :
		READ_ZERO;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_tgl_reg <= 1'b0;
			resp_data_reg <= READ_ZERO;
		end else if (ce && req_pulse) begin
			resp_data_reg <= mr_rd ? rd_mux : READ_ZERO;
			ack_tgl_reg <= ~ack_tgl_reg;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_flag_on_change: assert property (ce && code_change |=> temp_flag_reg)
		else $error("change flag not set after code change");
	a_flag_read_clear: assert property (ce && rd_thermal && !code_change |=> !temp_flag_reg)
		else $error("change flag not cleared by read");
	a_idle_before_init: assert property (!init_seen_reg && !init_s2_reg |->
		refresh_code_reg == CODE_NOMINAL && !temp_flag_reg)
		else $error("status moved before initialisation");
	a_derate_code: assert property (ce && init_s2_reg && derate_s2_reg |=>
		refresh_code_reg == CODE_DERATE)
		else $error("derating code not reported");
	a_entry_refused: assert property (ce && wr_thermal && protect_reg && !repair_mode |=>
		!repair_mode)
		else $error("repair entry taken while protected");
	a_protect_sticky: assert property (protect_reg |=> protect_reg)
		else $error("protection bit dropped");
	a_thermal_bits: assert property (ce && wr_thermal && !protect_reg |=>
		therm_wr_reg == $past(wdata[THERM_WR_HI:THERM_WR_LO]))
		else $error("thermal write field mismatch");
	a_ref_reserved: assert property (ce && wr_ref && !ref_code_ok |=>
		$stable(sp_reg[0].ref_code) && $stable(sp_reg[1].ref_code))
		else $error("reserved reference code accepted");
	a_term_reserved: assert property (ce && wr_term && !term_dq_ok |=>
		$stable(sp_reg[0].dq_term) && $stable(sp_reg[1].dq_term))
		else $error("reserved termination code accepted");
	a_copy_isolated: assert property (ce && (wr_term || wr_ref) && wsp_reg |=>
		$stable(sp_reg[0]))
		else $error("write reached inactive copy");
	a_active_copy: assert property (ce |=> act_reg == $past(sp_reg[osp_reg]))
		else $error("outputs not from operating copy");
	a_restore_pulse: assert property (ce && mr_wr && sel_cal && wdata[CAL_RESTORE_BIT] |=>
		zq_restore ##1 (!zq_restore || !$past(ce)))
		else $error("calibration restore pulse wrong");
	a_strap_fixed: assert property (strap_taken |=> $stable(cal_default_reg))
		else $error("calibration strap changed");
	a_read_pulse: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		rd_valid |=> !rd_valid && cmd_ready)
		else $error("read answer longer than one cycle");

	c_flag_read: cover property (ce && rd_thermal && temp_flag_reg);
	c_ref_write: cover property (ce && wr_ref && ref_code_ok && wsp_reg);
	c_entry_refused: cover property (ce && wr_thermal && entry_refused);
	c_setpoint_swap: cover property (ce && mr_wr && sel_setpoint && wdata[OSP_BIT] != osp_reg);

endmodule

// File: tb/mr_host_model.sv
// host controller model issuing mode register writes and reads on the link
`timescale 1ns/10ps
module mr_host_model import dram_mr_pkg::*; (
	input wire logic link_clk,
	input wire logic cmd_ready,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output mr_cmd_t cmd,
	output logic cmd_valid
);
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// refresh interval scale in quarters; zero marks codes that cannot be trusted
	function automatic int refresh_quarters(input logic [2:0] code);
		if (code == 3'h0 || code == 3'h7) begin
			return 0;
		end
		return (code == 3'h6) ? 1 : (16 >> (code - 3'h1));
	endfunction

	// one command, held until taken; gap 0 only straight after a link edge
	task automatic xfer(input logic wr, input logic [5:0] a, input logic [7:0] d,
		input int gap, output logic [7:0] q, output logic ok);
		int n;
		q = 8'h00;
		repeat (gap) @(posedge link_clk);
		cmd_valid <= 1'b1;
		cmd <= '{write: wr, addr: a, data: d};
		n = 0;
		do begin
			@(posedge link_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 64);
		cmd_valid <= 1'b0;
		// a released bus shows no stale command
		cmd <= ~cmd;
		n = 0;
		do begin
			@(posedge link_clk);
			n++;
		end while ((wr ? cmd_ready : rd_valid) !== 1'b1 && n < 64);
		q = rd_data;
		ok = (n < 64);
	endtask
endmodule

// File: tb/tb_dram_mode_register_file.sv
// self-checking bench for the mode register file
`timescale 1ns/10ps
module tb_dram_mode_register_file import dram_mr_pkg::*;;
	localparam logic [7:0] ID_CODE = 8'hC3; // arbitrary value
	localparam logic [7:0] REV_A = 8'h21; // arbitrary value
	localparam logic [7:0] REV_B = 8'h12; // arbitrary value
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic [2:0] temp_code = 3'h0;
	logic derate_req = 1'b0;
	logic init_done = 1'b0;
	logic cal_pin_grounded = 1'b0;
	logic cmd_valid, cmd_ready, rd_valid, repair_mode, zq_restore, cal_default_only, ref_range;
	mr_cmd_t cmd;
	logic [7:0] rd_data, q;
	logic [1:0] thermal_offset;
	logic [2:0] dq_term, ca_term;
	logic [5:0] ref_code;
	logic ok;
	logic after_rd = 1'b0;
	int mismatches = 0;
	int tests_run = 0;
	int cycles = 0;
	int zq_pulses = 0;
	// refresh interval scale in quarters per reported code; zero for untrusted codes
	int exp_quarters[8] = '{0, 16, 8, 4, 2, 1, 1, 0};

	always #4 clk = ~clk;
	initial begin
		#3.3;
		forever #80 link_clk = ~link_clk;
	end

	dram_mode_register_file #(.MAKER_ID(ID_CODE), .REV_FIRST(REV_A), .REV_SECOND(REV_B)) uut (
		.clk(clk), .rst_n(rst_n), .ce(ce), .link_clk(link_clk), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.temp_code(temp_code), .derate_req(derate_req), .init_done(init_done),
		.cal_pin_grounded(cal_pin_grounded), .repair_mode(repair_mode),
		.thermal_offset(thermal_offset), .zq_restore(zq_restore),
		.cal_default_only(cal_default_only), .dq_term(dq_term), .ca_term(ca_term),
		.ref_code(ref_code), .ref_range(ref_range));

	mr_host_model host (.link_clk(link_clk), .cmd_ready(cmd_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .cmd(cmd), .cmd_valid(cmd_valid));

	always @(posedge clk) begin
		if (zq_restore === 1'b1) begin
			zq_pulses++;
		end
	end

	task automatic print_verdict();
		$display("checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// the whole run needs well under forty thousand core cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end

	// ------------------------------
	// access tasks
	// ------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_op(input logic [12:0] e);
		chk("operating copy", {3'h0, e}, {3'h0, dq_term, ca_term, ref_range, ref_code});
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, 1, q, ok);
		chk("write done", 16'h1, {15'h0, ok});
		repeat (4) @(posedge clk);
		after_rd = 1'b0;
	endtask

	// consecutive reads go back to back on the link
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		host.xfer(1'b0, a, 8'h00, after_rd ? 0 : 1, q, ok);
		chk("read done", 16'h1, {15'h0, ok});
		chk("read data", {8'h00, e}, {8'h00, q});
		after_rd = 1'b1;
	endtask

	task automatic core(input logic [2:0] t, input logic dr, input logic id);
		@(posedge clk);
		temp_code <= t;
		derate_req <= dr;
		init_done <= id;
		repeat (8) @(posedge clk);
		after_rd = 1'b0;
	endtask

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		repeat (2) @(posedge link_clk);
		chk_op({3'h0, 3'h0, 1'b1, 6'h0D});
		chk("reset repair", 16'h0, {15'h0, repair_mode});
		@(posedge clk);
		rst_n <= 1'b1;
		rd(MA_MAKER, ID_CODE);
		rd(MA_REV_FIRST, REV_A);
		rd(MA_REV_SECOND, REV_B);
		rd(MA_GEOMETRY, 8'h00);
		rd(6'h3F, 8'h00);
		rd(MA_CA_REF, 8'h4D);
		wr(MA_GEOMETRY, 8'hFF);
		rd(MA_GEOMETRY, 8'h00);
		core(3'h5, 1'b0, 1'b0);
		rd(MA_THERMAL, 8'h03);
		core(3'h3, 1'b0, 1'b1);
		rd(MA_THERMAL, 8'h03);
		for (int i = 0; i < 8; i++) begin
			core(3'(i), 1'b0, 1'b1);
			rd(MA_THERMAL, {5'b10000, 3'(i)});
			chk("refresh quarters", 16'(exp_quarters[i]), 16'(host.refresh_quarters(q[2:0])));
			rd(MA_THERMAL, {5'b00000, 3'(i)});
		end
		core(3'h1, 1'b1, 1'b1);
		rd(MA_THERMAL, 8'h86);
		wr(MA_THERMAL, 8'hFF);
		chk("repair mode", 16'h1, {15'h0, repair_mode});
		chk("thermal offset", 16'h3, {14'h0, thermal_offset});
		rd(MA_THERMAL, 8'h06);
		wr(MA_THERMAL, 8'h20);
		chk("repair mode", 16'h0, {15'h0, repair_mode});
		chk("thermal offset", 16'h1, {14'h0, thermal_offset});
		wr(MA_PROTECT, 8'h04);
		wr(MA_THERMAL, 8'h50);
		chk("repair mode", 16'h0, {15'h0, repair_mode});
		chk("thermal offset", 16'h2, {14'h0, thermal_offset});
		wr(MA_CAL_RESTORE, 8'h00);
		chk("restore pulses", 16'h0, zq_pulses[15:0]);
		wr(MA_CAL_RESTORE, 8'hFF);
		chk("restore pulses", 16'h1, zq_pulses[15:0]);
		rd(MA_CAL_RESTORE, 8'h00);
		chk("default cal", 16'h0, {15'h0, cal_default_only});
		wr(MA_SETPOINT, 8'h00);
		wr(MA_TERM, 8'h35);
		wr(MA_CA_REF, 8'h32);
		chk_op({3'h5, 3'h3, 1'b0, 6'h32});
		rd(MA_TERM, 8'h00);
		wr(MA_TERM, 8'h77);
		wr(MA_CA_REF, 8'h73);
		chk_op({3'h5, 3'h3, 1'b1, 6'h32});
		rd(MA_CA_REF, 8'h72);
		wr(MA_SETPOINT, 8'h40);
		wr(MA_TERM, 8'h62);
		wr(MA_CA_REF, 8'h05);
		chk_op({3'h5, 3'h3, 1'b1, 6'h32});
		rd(MA_CA_REF, 8'h05);
		rd(MA_SETPOINT, 8'h40);
		wr(MA_SETPOINT, 8'hC0);
		chk_op({3'h2, 3'h6, 1'b0, 6'h05});
		for (int j = 0; j < 7; j++) begin
			wr(MA_TERM, {1'b0, 3'(6 - j), 1'b0, 3'(j)});
			chk_op({3'(j), 3'(6 - j), 1'b0, 6'h05});
		end
		wr(MA_SETPOINT, 8'h80);
		rd(MA_CA_REF, 8'h72);
		chk_op({3'h6, 3'h0, 1'b0, 6'h05});
		// second reset with the calibration pin grounded
		@(posedge clk);
		rst_n <= 1'b0;
		cal_pin_grounded <= 1'b1;
		repeat (2) @(posedge link_clk);
		chk_op({3'h0, 3'h0, 1'b1, 6'h0D});
		@(posedge clk);
		rst_n <= 1'b1;
		wr(MA_THERMAL, 8'h10);
		chk("repair mode", 16'h1, {15'h0, repair_mode});
		chk("default cal", 16'h1, {15'h0, cal_default_only});
		print_verdict();
	end
endmodule
